// File: temp_alarm_pkg.sv
package temp_alarm_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 200;        // system clock rate
    localparam int unsigned SPIKE_NS = 50;        // widest rejected spike
    // longest time, so rounded down
    localparam int unsigned SPIKE_CYC = (SPIKE_NS * CLK_MHZ) / 1000;
    localparam int unsigned TIMEOUT_MS = 37;      // bus stall timeout
    localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int unsigned TMO_W = 23;           // holds TIMEOUT_CYC

    // ------------------------------------------------------------
    // bus addresses
    // ------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR = 7'h2a;    // arbitrary default
    localparam logic [6:0] ARA_ADDR = 7'h0c;      // alert response address

    // ------------------------------------------------------------
    // byte register pointers
    // ------------------------------------------------------------
    localparam logic [7:0] PTR_LOCAL = 8'h00;     // local temperature
    localparam logic [7:0] PTR_REMOTE = 8'h01;    // remote temperature
    localparam logic [7:0] PTR_STATUS = 8'h02;    // status, read acks alert
    localparam logic [7:0] PTR_HI = 8'h03;        // high alert limit
    localparam logic [7:0] PTR_LO = 8'h04;        // low alert limit
    localparam logic [7:0] PTR_OT = 8'h05;        // overtemp limit

    // ------------------------------------------------------------
    // reset values and status bit positions
    // ------------------------------------------------------------
    localparam logic [7:0] HI_RST = 8'h55;
    localparam logic [7:0] LO_RST = 8'h00;
    localparam logic [7:0] OT_RST = 8'h55;
    localparam int unsigned ST_DIODE = 2;         // diode open or short
    localparam int unsigned ST_RLO = 3;           // remote below low
    localparam int unsigned ST_LLO = 4;           // local below low
    localparam int unsigned ST_RHI = 5;           // remote above high
    localparam int unsigned ST_LHI = 6;           // local above high

    // ------------------------------------------------------------
    // serial slave states
    // ------------------------------------------------------------
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_CMD = 9'h008,
        ST_CMD_ACK = 9'h010,
        ST_WDATA = 9'h020,
        ST_WDATA_ACK = 9'h040,
        ST_RDATA = 9'h080,
        ST_RDATA_ACK = 9'h100
    } smb_state_t;

endpackage

// File: pin_deglitch.sv
`timescale 1ns/1ps
module pin_deglitch #(
    parameter int unsigned SPIKE_CYC = 10,
    parameter logic RST_VAL = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic pin_i,
    output logic clean_o
);
    // ------------------------------------------------------------
    // two-stage sync then spike filter
    // ------------------------------------------------------------
    localparam int unsigned CW = $clog2(SPIKE_CYC + 1);
    localparam logic [CW-1:0] LIM = CW'(SPIKE_CYC);

    logic meta;           // first stage, read only by sync
    logic sync;           // second stage
    logic clean;          // filtered level
    logic [CW-1:0] cnt;   // cycles the sync level has differed
    logic next_clean;
    logic [CW-1:0] next_cnt;

    assign clean_o = clean;

    // level must differ for LIM+1 cycles before it is taken
    always_comb begin
        next_clean = clean;
        next_cnt = '0;
        if (sync != clean) begin
            if (cnt == LIM) begin
                next_clean = sync; // RULE6
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    // registers only
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            meta <= RST_VAL;
            sync <= RST_VAL;
            clean <= RST_VAL;
            cnt <= '0;
        end else begin
            meta <= pin_i;
            sync <= meta;
            clean <= next_clean;
            cnt <= next_cnt;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_spike_reject: assert property ( // RULE6
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clean != $past(clean)) |-> ($past(cnt) == LIM))
        else $error("filtered level moved before spike window");
endmodule

// File: temp_alarm_serial_port.sv
`timescale 1ns/1ps
// How it works
// RULE1 - clock held low past timeout resets slave
// RULE2 - overtemp pin low while temperature above limit
// RULE3 - alert asserts above high or below low
// RULE4 - alert latched until status read or ARA
// RULE5 - acknowledge releases alert only when fault gone
// RULE6 - pulses up to 50 ns are ignored
// RULE7 - remote diode open or short asserts alert
// RULE8 - byte read/write/send/receive at one address
// RULE9 - timeout restarts on clock high, slave idles
module temp_alarm_serial_port #(
    parameter int unsigned TIMEOUT_CYC = temp_alarm_pkg::TIMEOUT_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    output logic smb_alert_n_o,
    output logic smb_alert_n_oe_n_o,
    output logic overtemp_shutdown_out_n_o,
    output logic overtemp_shutdown_out_n_oe_n_o,
    input wire logic [7:0] local_temp_i,
    input wire logic [7:0] remote_temp_i,
    input wire logic remote_diode_fault_i
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam int unsigned TW = temp_alarm_pkg::TMO_W;
    localparam logic [TW-1:0] TMO_LAST = TW'(TIMEOUT_CYC - 1);

    logic scl_f, sda_f;          // filtered pin levels
    logic scl_q, sda_q;          // previous filtered levels
    logic scl_rise, scl_fall, start, stop, tmo_hit;
    temp_alarm_pkg::smb_state_t state, next_state;
    logic [2:0] bit_cnt, next_bit_cnt;     // bits seen in this byte
    logic [7:0] shreg, next_shreg;         // rx or tx byte
    logic flag, next_flag;                 // byte done, or master ack
    logic [7:0] pointer, next_pointer;     // selected register
    logic rd_mode, next_rd_mode;           // read transfer
    logic ara, next_ara;                   // alert response in progress
    logic sda_oe_n, next_sda_oe_n;
    logic [7:0] hi_lim, next_hi, lo_lim, next_lo, ot_lim, next_ot;
    logic status_ack, next_status_ack;     // status byte sent
    logic ara_ack, next_ara_ack;           // ara address sent
    logic [TW-1:0] tmo_cnt, next_tmo;      // clock-low time
    logic alert_oe_n, next_alert_oe_n;
    logic ot_oe_n, next_ot_oe_n;
    logic [7:0] status, rd_data;
    logic fault, lim_fault, hot;

    // ------------------------------------------------------------
    // pin filters
    // ------------------------------------------------------------
    pin_deglitch #(.SPIKE_CYC(temp_alarm_pkg::SPIKE_CYC), .RST_VAL(1'b1))
        u_scl (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .pin_i(scl_i),
               .clean_o(scl_f));
    pin_deglitch #(.SPIKE_CYC(temp_alarm_pkg::SPIKE_CYC), .RST_VAL(1'b1))
        u_sda (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .pin_i(sda_i),
               .clean_o(sda_f));

    // bus events from filtered levels
    assign scl_rise = scl_f & ~scl_q;
    assign scl_fall = ~scl_f & scl_q;
    assign start = scl_f & scl_q & sda_q & ~sda_f;
    assign stop = scl_f & scl_q & ~sda_q & sda_f;
    assign tmo_hit = ~scl_f & (tmo_cnt == TMO_LAST); // RULE1

    // ------------------------------------------------------------
    // alarm conditions
    // ------------------------------------------------------------
    always_comb begin
        status = 8'h00;
        status[temp_alarm_pkg::ST_LHI] =
            $signed(local_temp_i) > $signed(hi_lim);
        status[temp_alarm_pkg::ST_RHI] =
            $signed(remote_temp_i) > $signed(hi_lim);
        status[temp_alarm_pkg::ST_LLO] =
            $signed(local_temp_i) < $signed(lo_lim);
        status[temp_alarm_pkg::ST_RLO] =
            $signed(remote_temp_i) < $signed(lo_lim);
        status[temp_alarm_pkg::ST_DIODE] = remote_diode_fault_i; // RULE7
        lim_fault = |status[temp_alarm_pkg::ST_LHI:temp_alarm_pkg::ST_RLO];
        fault = lim_fault | remote_diode_fault_i; // RULE3 RULE7
        hot = ($signed(local_temp_i) > $signed(ot_lim))
            | ($signed(remote_temp_i) > $signed(ot_lim));
        // alert held until an ack finds the fault gone
        next_alert_oe_n = ~(fault
            | (~alert_oe_n & ~(status_ack | ara_ack))); // RULE4 RULE5
        next_ot_oe_n = ~hot; // RULE2
    end

    // read mux; unknown pointers read zero
    always_comb begin
        case (pointer)
            temp_alarm_pkg::PTR_LOCAL: rd_data = local_temp_i;
            temp_alarm_pkg::PTR_REMOTE: rd_data = remote_temp_i;
            temp_alarm_pkg::PTR_STATUS: rd_data = status;
            temp_alarm_pkg::PTR_HI: rd_data = hi_lim;
            temp_alarm_pkg::PTR_LO: rd_data = lo_lim;
            temp_alarm_pkg::PTR_OT: rd_data = ot_lim;
            default: rd_data = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // serial slave next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_flag = flag;
        next_pointer = pointer;
        next_rd_mode = rd_mode;
        next_ara = ara;
        next_sda_oe_n = sda_oe_n;
        next_hi = hi_lim;
        next_lo = lo_lim;
        next_ot = ot_lim;
        next_status_ack = 1'b0;
        next_ara_ack = 1'b0;
        // stall counter restarts whenever the clock is high
        if (scl_f) begin
            next_tmo = '0; // RULE9
        end else if (tmo_cnt != TMO_LAST) begin
            next_tmo = tmo_cnt + 1'b1;
        end else begin
            next_tmo = tmo_cnt;
        end
        if (tmo_hit || stop) begin
            // release data and wait for a fresh start
            next_state = temp_alarm_pkg::ST_IDLE; // RULE1 RULE9
            next_sda_oe_n = 1'b1;
        end else if (start) begin
            // also a repeated start; pointer is kept
            next_state = temp_alarm_pkg::ST_ADDR;
            next_bit_cnt = 3'h0;
            next_flag = 1'b0;
            next_sda_oe_n = 1'b1;
        end else if (scl_rise) begin
            next_bit_cnt = bit_cnt + 3'h1;
            next_flag = (bit_cnt == 3'h7);
            case (state)
                temp_alarm_pkg::ST_ADDR, temp_alarm_pkg::ST_CMD,
                temp_alarm_pkg::ST_WDATA: begin
                    next_shreg = {shreg[6:0], sda_f};
                end
                temp_alarm_pkg::ST_RDATA: begin
                    // lost ara arbitration to a lower address
                    if (ara && sda_oe_n && !sda_f) begin
                        next_state = temp_alarm_pkg::ST_IDLE;
                    end
                end
                temp_alarm_pkg::ST_RDATA_ACK: begin
                    next_flag = ~sda_f; // master ack
                    next_ara_ack = ara; // RULE4
                    next_status_ack = ~ara
                        & (pointer == temp_alarm_pkg::PTR_STATUS); // RULE4
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state)
                temp_alarm_pkg::ST_ADDR: begin
                    if (flag) begin
                        if (shreg[7:1] == temp_alarm_pkg::SLAVE_ADDR
                            || (shreg[7:1] == temp_alarm_pkg::ARA_ADDR
                                && shreg[0])) begin
                            next_state = temp_alarm_pkg::ST_ADDR_ACK; // RULE8
                            next_sda_oe_n = 1'b0;
                            next_rd_mode = shreg[0];
                            next_ara = shreg[7:1] == temp_alarm_pkg::ARA_ADDR;
                        end else begin
                            next_state = temp_alarm_pkg::ST_IDLE;
                        end
                    end
                end
                temp_alarm_pkg::ST_ADDR_ACK, temp_alarm_pkg::ST_RDATA_ACK: begin
                    next_bit_cnt = 3'h0;
                    next_flag = 1'b0;
                    if (state == temp_alarm_pkg::ST_RDATA_ACK && !flag) begin
                        // master nack ends the read
                        next_state = temp_alarm_pkg::ST_IDLE;
                        next_sda_oe_n = 1'b1;
                    end else if (rd_mode) begin
                        // receive byte, or read byte after repeated start
                        next_state = temp_alarm_pkg::ST_RDATA; // RULE8
                        next_shreg = ara ? {temp_alarm_pkg::SLAVE_ADDR, 1'b1}
                                         : rd_data;
                        next_sda_oe_n = ara ? temp_alarm_pkg::SLAVE_ADDR[6]
                                            : rd_data[7];
                    end else begin
                        next_state = temp_alarm_pkg::ST_CMD;
                        next_sda_oe_n = 1'b1;
                    end
                end
                temp_alarm_pkg::ST_CMD: begin
                    if (flag) begin
                        // send byte ends here, write byte goes on
                        next_pointer = shreg; // RULE8
                        next_state = temp_alarm_pkg::ST_CMD_ACK;
                        next_sda_oe_n = 1'b0;
                    end
                end
                temp_alarm_pkg::ST_WDATA: begin
                    if (flag) begin
                        next_state = temp_alarm_pkg::ST_WDATA_ACK;
                        next_sda_oe_n = 1'b0;
                        // read-only pointers drop the data
                        case (pointer)
                            temp_alarm_pkg::PTR_HI: next_hi = shreg; // RULE8
                            temp_alarm_pkg::PTR_LO: next_lo = shreg;
                            temp_alarm_pkg::PTR_OT: next_ot = shreg;
                            default: begin
                            end
                        endcase
                    end
                end
                temp_alarm_pkg::ST_CMD_ACK, temp_alarm_pkg::ST_WDATA_ACK: begin
                    next_state = temp_alarm_pkg::ST_WDATA;
                    next_sda_oe_n = 1'b1;
                    next_bit_cnt = 3'h0;
                    next_flag = 1'b0;
                end
                temp_alarm_pkg::ST_RDATA: begin
                    if (flag) begin
                        next_state = temp_alarm_pkg::ST_RDATA_ACK;
                        next_sda_oe_n = 1'b1;
                    end else begin
                        next_shreg = {shreg[6:0], 1'b0};
                        next_sda_oe_n = shreg[6];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            state <= temp_alarm_pkg::ST_IDLE;
            bit_cnt <= 3'h0;
            shreg <= 8'h00;
            flag <= 1'b0;
            pointer <= 8'h00;
            rd_mode <= 1'b0;
            ara <= 1'b0;
            sda_oe_n <= 1'b1;
            hi_lim <= temp_alarm_pkg::HI_RST;
            lo_lim <= temp_alarm_pkg::LO_RST;
            ot_lim <= temp_alarm_pkg::OT_RST;
            status_ack <= 1'b0;
            ara_ack <= 1'b0;
            tmo_cnt <= '0;
            alert_oe_n <= 1'b1;
            ot_oe_n <= 1'b1;
        end else begin
            scl_q <= scl_f;
            sda_q <= sda_f;
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            flag <= next_flag;
            pointer <= next_pointer;
            rd_mode <= next_rd_mode;
            ara <= next_ara;
            sda_oe_n <= next_sda_oe_n;
            hi_lim <= next_hi;
            lo_lim <= next_lo;
            ot_lim <= next_ot;
            status_ack <= next_status_ack;
            ara_ack <= next_ara_ack;
            tmo_cnt <= next_tmo;
            alert_oe_n <= next_alert_oe_n;
            ot_oe_n <= next_ot_oe_n;
        end
    end

    // open-drain pins only ever drive low
    assign sda_o = 1'b0;
    assign smb_alert_n_o = 1'b0;
    assign overtemp_shutdown_out_n_o = 1'b0;
    assign sda_oe_n_o = sda_oe_n;
    assign smb_alert_n_oe_n_o = alert_oe_n;
    assign overtemp_shutdown_out_n_oe_n_o = ot_oe_n;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_ack_fault_gone;
        !alert_oe_n && (status_ack || ara_ack) && !fault;
    endsequence
    sequence s_hold_no_ack;
        !alert_oe_n && !status_ack && !ara_ack;
    endsequence

    a_timeout_reset: assert property (tmo_hit |=> // RULE1
        state == temp_alarm_pkg::ST_IDLE && sda_oe_n_o)
        else $error("slave not idle after clock stall");
    a_timeout_restart: assert property (scl_f |=> tmo_cnt == '0) // RULE9
        else $error("stall counter kept running with clock high");
    a_overtemp_pin: assert property (hot ##1 hot |=> // RULE2
        !overtemp_shutdown_out_n_oe_n_o)
        else $error("overtemp pin not driven while hot");
    a_overtemp_release: assert property (!hot ##1 !hot |=> // RULE2
        overtemp_shutdown_out_n_oe_n_o)
        else $error("overtemp pin driven while cool");
    a_alert_on_limit: assert property (lim_fault |=> // RULE3
        !smb_alert_n_oe_n_o)
        else $error("alert missing on limit crossing");
    a_alert_diode: assert property (remote_diode_fault_i |=> // RULE7
        !smb_alert_n_oe_n_o)
        else $error("alert missing on diode fault");
    a_alert_latched: assert property (s_hold_no_ack |=> // RULE4
        !smb_alert_n_oe_n_o)
        else $error("alert dropped without acknowledge");
    a_ack_release: assert property (s_ack_fault_gone |=> // RULE5
        smb_alert_n_oe_n_o)
        else $error("alert not released by acknowledge");
    a_fault_persist: assert property ((status_ack || ara_ack) // RULE5
        && fault |=> !smb_alert_n_oe_n_o)
        else $error("alert released while fault present");
    a_addr_ack: assert property (state == temp_alarm_pkg::ST_ADDR // RULE8
        && scl_fall && flag && !start && !stop && !tmo_hit
        && shreg[7:1] == temp_alarm_pkg::SLAVE_ADDR
        |=> !sda_oe_n_o ##0 state == temp_alarm_pkg::ST_ADDR_ACK)
        else $error("own address not acknowledged");
endmodule

// File: smb_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// bus host: open-drain data, slow clock, one result per byte
// ------------------------------------------------------------
module smb_host_model #(
    parameter int HALF = 30 // cycles per clock phase, well over 60 ns
) (
    input wire logic sys_clk_i,
    input wire logic sda_oe_n_i, // device pulls data low when low
    output logic scl_o,
    output logic sda_o, // resolved data wire
    output logic res_valid_o, // one-cycle strobe per result
    output logic [7:0] res_data_o
);
    logic host_sda = 1'b1; // host side of the wire, 1 = released
    // pull-up wire: a released line floats high, never holds old data
    assign sda_o = host_sda & sda_oe_n_i;
    initial begin
        scl_o = 1'b1;
        res_valid_o = 1'b0;
        res_data_o = 8'h00;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    // lines only move after a whole phase, so setup and hold hold
    task automatic step(input logic c, input logic d);
        wait_cyc(HALF);
        scl_o <= c;
        host_sda <= d;
    endtask
    // start or repeated start, clock left low
    task automatic start_c();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
    // stop, then a bus-free gap
    task automatic stop_c();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b1, 1'b1);
    endtask
    // one bit, sampled at the end of the high phase; g adds a 40 ns spike
    task automatic clk_bit(input logic b, input logic g, output logic s);
        if (g) begin
            wait_cyc(10);
            scl_o <= 1'b1;
            wait_cyc(8);
            scl_o <= 1'b0;
        end
        step(1'b0, b);
        step(1'b1, b);
        wait_cyc(HALF);
        s = sda_o;
        scl_o <= 1'b0;
    endtask
    task automatic report(input logic [7:0] d);
        res_data_o <= d;
        res_valid_o <= 1'b1;
        @(posedge sys_clk_i);
        res_valid_o <= 1'b0;
    endtask
    // byte out msb first, then the ack slot, reported as 1 for ack
    task automatic put_byte(input logic [7:0] d, input logic g);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], g, s);
        end
        clk_bit(1'b1, 1'b0, s);
        report({7'h00, !s});
    endtask
    // byte in, then a master nack to end the read
    task automatic get_byte();
        logic [7:0] d;
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, 1'b0, s);
            d[i] = s;
        end
        clk_bit(1'b1, 1'b0, s);
        report(d);
    endtask
endmodule

// File: temp_alarm_serial_port_test.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin \
    failures++; $display("Error %s: expected %h, seen %h", nm, ex, gt); end end
module temp_alarm_serial_port_test;
    // --------------------------------------------------------
    // wiring and expectation notes
    // --------------------------------------------------------
    localparam int TMO = 400; // short stall timeout, above a clock phase
    localparam logic [7:0] WA = {temp_alarm_pkg::SLAVE_ADDR, 1'b0};
    localparam logic [7:0] RA = {temp_alarm_pkg::SLAVE_ADDR, 1'b1};
    localparam logic [7:0] AA = {temp_alarm_pkg::ARA_ADDR, 1'b1};
    typedef struct {
        string name;
        int kind; // 0 bus result, 1 alert, 2 overtemp, 3 data drive
        logic [7:0] val;
    } note_t;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] local_temp = 8'h10;
    logic [7:0] remote_temp = 8'h10;
    logic diode_fault = 1'b0;
    logic probe = 1'b0; // asks the watcher to look at the pins
    logic scl, sda, sda_oe_n, alert_oe_n, ot_oe_n, res_valid;
    logic [7:0] res_data, seen;
    logic [3:0] pins;
    note_t note;
    note_t notes[$]; // oldest expectation first
    int failures = 0;
    int total_checks = 0;
    assign pins = {sda_oe_n, ot_oe_n, alert_oe_n, 1'b0};
    always #2.5 sys_clk_i = ~sys_clk_i;
    temp_alarm_serial_port #(.TIMEOUT_CYC(TMO)) u_dut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
        .sda_o(), .sda_oe_n_o(sda_oe_n), .smb_alert_n_o(),
        .smb_alert_n_oe_n_o(alert_oe_n), .overtemp_shutdown_out_n_o(),
        .overtemp_shutdown_out_n_oe_n_o(ot_oe_n), .local_temp_i(local_temp),
        .remote_temp_i(remote_temp), .remote_diode_fault_i(diode_fault));
    smb_host_model #(.HALF(30)) u_host (
        .sys_clk_i(sys_clk_i), .sda_oe_n_i(sda_oe_n), .scl_o(scl),
        .sda_o(sda), .res_valid_o(res_valid), .res_data_o(res_data));
    // --------------------------------------------------------
    // watcher: oldest note against whatever result shows up
    // --------------------------------------------------------
    always @(posedge sys_clk_i) begin
        if (res_valid || probe) begin
            note = notes.pop_front();
            seen = note.kind == 0 ? res_data : {7'h00, pins[note.kind]};
            `CHK(note.name, note.val, seen)
        end
    end
    // pins are looked at a few cycles on, past the one-cycle latency
    task automatic look(input int k, input string nm, input logic v);
        repeat (4) @(posedge sys_clk_i);
        notes.push_back('{nm, k, {7'h00, v}});
        probe <= 1'b1;
        @(posedge sys_clk_i);
        probe <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] b, input logic a, input logic g = 0);
        notes.push_back('{"ack", 0, {7'h00, a}});
        u_host.put_byte(b, g);
    endtask
    task automatic rd(input logic [7:0] v);
        notes.push_back('{"read byte", 0, v});
        u_host.get_byte();
    endtask
    task automatic write_reg(input logic [7:0] p, v, input logic g = 0);
        u_host.start_c();
        wr(WA, 1'b1);
        wr(p, 1'b1);
        wr(v, 1'b1, g);
        u_host.stop_c();
    endtask
    task automatic read_reg(input logic [7:0] p, v);
        u_host.start_c();
        wr(WA, 1'b1);
        wr(p, 1'b1);
        u_host.start_c();
        wr(RA, 1'b1);
        rd(v);
        u_host.stop_c();
    endtask
    // receive byte, or an alert response read when a is the alert address
    task automatic recv(input logic [7:0] a, v);
        u_host.start_c();
        wr(a, 1'b1);
        rd(v);
        u_host.stop_c();
    endtask
    task automatic temps(input logic [7:0] l, r, input logic f);
        @(posedge sys_clk_i);
        local_temp <= l;
        remote_temp <= r;
        diode_fault <= f;
    endtask
    task automatic complete_run();
        $display("checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        logic [7:0] l, r;
        void'($urandom(32'h6a78));
        repeat (6) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        look(1, "alert", 1'b1);
        look(2, "overtemp", 1'b1);
        // spikes on the clock low phases of the data byte's bits must not add bits
        write_reg(temp_alarm_pkg::PTR_HI, 8'h30, 1'b1);
        read_reg(temp_alarm_pkg::PTR_HI, 8'h30);
        recv(RA, 8'h30);
        u_host.start_c(); // send byte only moves the pointer
        wr(WA, 1'b1);
        wr(temp_alarm_pkg::PTR_LO, 1'b1);
        u_host.stop_c();
        recv(RA, temp_alarm_pkg::LO_RST);
        temps(8'h31, 8'h10, 1'b0);
        look(1, "alert", 1'b0);
        read_reg(temp_alarm_pkg::PTR_STATUS, 8'h40);
        look(1, "alert", 1'b0);
        temps(8'h10, 8'h10, 1'b0);
        look(1, "alert", 1'b0);
        read_reg(temp_alarm_pkg::PTR_STATUS, 8'h00);
        look(1, "alert", 1'b1);
        temps(8'h10, 8'hf0, 1'b0); // negative remote, below low limit
        look(1, "alert", 1'b0);
        temps(8'h10, 8'h10, 1'b1);
        read_reg(temp_alarm_pkg::PTR_STATUS, 8'h04);
        look(1, "alert", 1'b0);
        temps(8'h10, 8'h10, 1'b0);
        recv(AA, RA);
        look(1, "alert", 1'b1);
        u_host.start_c(); // a foreign address is ignored
        wr(8'h20, 1'b0);
        u_host.stop_c();
        read_reg(8'h07, 8'h00);
        // stall with the clock low while the device drives a 0 bit
        u_host.start_c();
        wr(RA, 1'b1);
        u_host.wait_cyc(40);
        look(3, "data drive", 1'b0);
        u_host.wait_cyc(TMO);
        look(3, "data drive", 1'b1);
        u_host.stop_c();
        recv(RA, 8'h00);
        write_reg(temp_alarm_pkg::PTR_OT, 8'h20);
        for (int i = 0; i < 10; i++) begin
            l = i == 0 ? 8'h20 : i == 1 ? 8'h21 : 8'($urandom);
            r = 8'($urandom);
            temps(l, r, 1'b0);
            look(2, "overtemp",
                !($signed(l) > 8'sh20 || $signed(r) > 8'sh20));
        end
        complete_run();
    end
    // watchdog, well beyond the expected run length
    initial begin
        repeat (90000) @(posedge sys_clk_i);
        failures++;
        $display("Error watchdog: expected end of tests, seen timeout");
        complete_run();
    end
endmodule
